// ==== ddhr_pkg.sv ====
// Package: register map, field positions and state record of the holding-register bank
package ddhr_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam int        ADDR_W     = 8;
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SWTRIG = 8'h04;
    localparam logic [7:0] OFS_C1R12  = 8'h08;
    localparam logic [7:0] OFS_C1L12  = 8'h0C;
    localparam logic [7:0] OFS_C1R8   = 8'h10;
    localparam logic [7:0] OFS_C2R12  = 8'h14;
    localparam logic [7:0] OFS_C2L12  = 8'h18;
    localparam logic [7:0] OFS_C2R8   = 8'h1C;
    localparam logic [7:0] OFS_D12R   = 8'h20;
    localparam logic [7:0] OFS_D12L   = 8'h24;
    localparam logic [7:0] OFS_OUT1   = 8'h2C;
    localparam logic [7:0] OFS_OUT2   = 8'h30;

    // ************************************************************
    // Fields, responses, reset values
    // ************************************************************
    localparam int         CH1_TRIG_EN = 2;
    localparam int         CH2_TRIG_EN = 18;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_ERR   = 2'h2;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [3:0] NIB_ZERO   = 4'h0;

    // ************************************************************
    // Whole state of the bank
    // ************************************************************
    typedef struct packed {
        logic                   aw_held;
        logic [ADDR_W-1:0]      aw_addr;
        logic                   w_held;
        logic [31:0]            w_data;
        logic [3:0]             w_strb;
        logic                   bvalid;
        logic [1:0]             bresp;
        logic                   rvalid;
        logic [31:0]            rdata;
        logic [1:0]             rresp;
        logic [1:0][11:0]       hold;
        logic [1:0][11:0]       latch;
        logic [1:0]             ten;
        logic [1:0]             swtrig;
        logic [1:0]             sw_done;
        logic [1:0]             hw_s1;
        logic [1:0]             hw_s2;
        logic [1:0]             hw_prev;
        logic [1:0][1:0]        pipe;
    } ddhr_state_t;

endpackage

// ==== ddhr_regs.sv ====
// Module: two-channel converter data holding registers behind an AXI4-Lite slave
//
// Function
// - Ch1 right 12-bit write takes bits 11:0
// - Ch1 left 12-bit write takes bits 15:4
// - Ch1 8-bit write takes bits 7:0
// - Ch2 right 12-bit write takes bits 11:0
// - Ch2 left 12-bit write takes bits 15:4
// - Ch2 8-bit write takes bits 7:0
// - Dual right write loads both channels
// - Dual left write loads both channels
// - Holding registers reset to zero, read/write
// - Transfer one cycle untriggered or after soft trigger, three after hardware trigger
// - Output latch holds value, read-only
// - Soft trigger clears one cycle after load
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps

module ddhr_regs (
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    input  wire logic [ddhr_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [ddhr_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    input  wire logic [1:0]                 hw_trigger,
    output logic [11:0]                     ch1_output_latch,
    output logic [11:0]                     ch2_output_latch
);

    ddhr_pkg::ddhr_state_t st;
    ddhr_pkg::ddhr_state_t next_st;
    logic                  wr_go;
    logic [1:0]            hw_edge;

    // ************************************************************
    // Register read view
    // ************************************************************
    // Each holding format reads back the shared channel value in its own alignment
    function automatic logic [31:0] rd_word(input logic [7:0] a,
                                            input ddhr_pkg::ddhr_state_t s);
        logic [31:0] v;
        v = ddhr_pkg::WORD_ZERO;
        case (a)
            ddhr_pkg::OFS_CTRL: begin
                v[ddhr_pkg::CH1_TRIG_EN] = s.ten[0];
                v[ddhr_pkg::CH2_TRIG_EN] = s.ten[1];
            end
            ddhr_pkg::OFS_SWTRIG: v[1:0] = s.swtrig;
            ddhr_pkg::OFS_C1R12:  v[11:0] = s.hold[0];
            ddhr_pkg::OFS_C1L12:  v[15:4] = s.hold[0];
            ddhr_pkg::OFS_C1R8:   v[7:0] = s.hold[0][11:4];
            ddhr_pkg::OFS_C2R12:  v[11:0] = s.hold[1];
            ddhr_pkg::OFS_C2L12:  v[15:4] = s.hold[1];
            ddhr_pkg::OFS_C2R8:   v[7:0] = s.hold[1][11:4];
            ddhr_pkg::OFS_D12R: begin
                v[27:16] = s.hold[1];
                v[11:0]  = s.hold[0];
            end
            ddhr_pkg::OFS_D12L: begin
                v[31:20] = s.hold[1];
                v[15:4]  = s.hold[0];
            end
            ddhr_pkg::OFS_OUT1:   v[11:0] = s.latch[0];
            ddhr_pkg::OFS_OUT2:   v[11:0] = s.latch[1];
            default: ;
        endcase
        return v;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            ddhr_pkg::OFS_CTRL, ddhr_pkg::OFS_SWTRIG, ddhr_pkg::OFS_C1R12,
            ddhr_pkg::OFS_C1L12, ddhr_pkg::OFS_C1R8, ddhr_pkg::OFS_C2R12,
            ddhr_pkg::OFS_C2L12, ddhr_pkg::OFS_C2R8, ddhr_pkg::OFS_D12R,
            ddhr_pkg::OFS_D12L, ddhr_pkg::OFS_OUT1, ddhr_pkg::OFS_OUT2: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // ************************************************************
    // Handshake outputs
    // ************************************************************
    assign s_axi_awready    = !st.aw_held;
    assign s_axi_wready     = !st.w_held;
    assign s_axi_arready    = !st.rvalid;
    assign s_axi_bvalid     = st.bvalid;
    assign s_axi_bresp      = st.bresp;
    assign s_axi_rvalid     = st.rvalid;
    assign s_axi_rdata      = st.rdata;
    assign s_axi_rresp      = st.rresp;
    assign ch1_output_latch = st.latch[0];
    assign ch2_output_latch = st.latch[1];

    // Write fires once address and data are both held and no answer is pending
    assign wr_go   = st.aw_held && st.w_held && !st.bvalid;
    // Edge taken from the second stage only; first stage feeds nothing else
    assign hw_edge = st.hw_s2 & ~st.hw_prev;

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [31:0] old;
        logic [31:0] wv;
        old     = rd_word(st.aw_addr, st);
        wv      = old;
        next_st = st;
        for (int i = 0; i < 4; i++) begin
            wv[8*i +: 8] = st.w_strb[i] ? st.w_data[8*i +: 8] : old[8*i +: 8];
        end

        next_st.hw_s1   = hw_trigger;
        next_st.hw_s2   = st.hw_s1;
        next_st.hw_prev = st.hw_s2;

        if (s_axi_awvalid && !st.aw_held) begin
            next_st.aw_held = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st.w_held) begin
            next_st.w_held = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !st.rvalid) begin
            next_st.rvalid = 1'b1;
            next_st.rdata  = rd_word(s_axi_araddr, st);
            next_st.rresp  = is_mapped(s_axi_araddr) ? ddhr_pkg::RESP_OKAY
                                                     : ddhr_pkg::RESP_ERR;
        end

        for (int ch = 0; ch < 2; ch++) begin
            // Hardware trigger walks two stages, load lands on the third edge
            next_st.pipe[ch] = {st.pipe[ch][0], hw_edge[ch] & st.ten[ch]};
            if (st.sw_done[ch]) begin
                next_st.swtrig[ch]  = 1'b0;
                next_st.sw_done[ch] = 1'b0;
            end
            if (!st.ten[ch]) begin
                next_st.latch[ch] = st.hold[ch];
            end else if (st.swtrig[ch] && !st.sw_done[ch]) begin
                next_st.latch[ch]   = st.hold[ch];
                next_st.sw_done[ch] = 1'b1;
            end else if (st.pipe[ch][1]) begin
                next_st.latch[ch] = st.hold[ch];
            end
        end

        // Placed after the hardware clear so that a software set wins
        if (wr_go) begin
            next_st.aw_held = 1'b0;
            next_st.w_held  = 1'b0;
            next_st.bvalid  = 1'b1;
            next_st.bresp   = ddhr_pkg::RESP_OKAY;
            case (st.aw_addr)
                ddhr_pkg::OFS_CTRL: begin
                    next_st.ten[0] = wv[ddhr_pkg::CH1_TRIG_EN];
                    next_st.ten[1] = wv[ddhr_pkg::CH2_TRIG_EN];
                end
                ddhr_pkg::OFS_SWTRIG: next_st.swtrig = next_st.swtrig | wv[1:0];
                ddhr_pkg::OFS_C1R12: next_st.hold[0] = wv[11:0];
                ddhr_pkg::OFS_C1L12: next_st.hold[0] = wv[15:4];
                ddhr_pkg::OFS_C1R8:  next_st.hold[0] = {wv[7:0], ddhr_pkg::NIB_ZERO};
                ddhr_pkg::OFS_C2R12: next_st.hold[1] = wv[11:0];
                ddhr_pkg::OFS_C2L12: next_st.hold[1] = wv[15:4];
                ddhr_pkg::OFS_C2R8:  next_st.hold[1] = {wv[7:0], ddhr_pkg::NIB_ZERO};
                ddhr_pkg::OFS_D12R: begin
                    next_st.hold[1] = wv[27:16];
                    next_st.hold[0] = wv[11:0];
                end
                ddhr_pkg::OFS_D12L: begin
                    next_st.hold[1] = wv[31:20];
                    next_st.hold[0] = wv[15:4];
                end
                // Output latches cannot be written by software
                default: next_st.bresp = ddhr_pkg::RESP_ERR;
            endcase
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    logic full_wr;
    assign full_wr = wr_go && (st.w_strb == 4'hF);

    c1_right_a: assert property (full_wr && st.aw_addr == ddhr_pkg::OFS_C1R12
        |=> st.hold[0] == $past(st.w_data[11:0])) else $error("ch1 right load");
    c1_left_a: assert property (full_wr && st.aw_addr == ddhr_pkg::OFS_C1L12
        |=> st.hold[0] == $past(st.w_data[15:4])) else $error("ch1 left load");
    c1_byte_a: assert property (full_wr && st.aw_addr == ddhr_pkg::OFS_C1R8
        |=> st.hold[0] == {$past(st.w_data[7:0]), 4'h0}) else $error("ch1 byte load");
    c2_left_a: assert property (full_wr && st.aw_addr == ddhr_pkg::OFS_C2L12
        |=> st.hold[1] == $past(st.w_data[15:4])) else $error("ch2 left load");
    dual_right_a: assert property (full_wr && st.aw_addr == ddhr_pkg::OFS_D12R
        |=> st.hold == {$past(st.w_data[27:16]), $past(st.w_data[11:0])})
        else $error("dual right load");
    dual_left_a: assert property (full_wr && st.aw_addr == ddhr_pkg::OFS_D12L
        |=> st.hold == {$past(st.w_data[31:20]), $past(st.w_data[15:4])})
        else $error("dual left load");
    hw_delay_a: assert property (hw_edge[0] && st.ten[0] && !st.swtrig[0]
        ##1 (st.ten[0] && !st.swtrig[0])[*2]
        |=> ch1_output_latch == $past(st.hold[0])) else $error("hw transfer delay");
    sw_clear_a: assert property (st.ten[0] && st.swtrig[0] && !st.sw_done[0]
        ##1 !(wr_go && st.aw_addr == ddhr_pkg::OFS_SWTRIG)
        |=> !st.swtrig[0]) else $error("soft trigger not cleared");
    c2_right_a: assert property (full_wr && st.aw_addr == ddhr_pkg::OFS_C2R12
        |=> st.hold[1] == $past(st.w_data[11:0])) else $error("ch2 right load");
    c2_byte_a: assert property (full_wr && st.aw_addr == ddhr_pkg::OFS_C2R8
        |=> st.hold[1] == {$past(st.w_data[7:0]), 4'h0}) else $error("ch2 byte load");
    ch2_hw_a: assert property (hw_edge[1] && st.ten[1] && !st.swtrig[1]
        ##1 (st.ten[1] && !st.swtrig[1])[*2]
        |=> ch2_output_latch == $past(st.hold[1])) else $error("ch2 hw transfer delay");
    // Latches are not writable; a write there must leave every holding value alone
    ro_resp_a: assert property (wr_go
        && (st.aw_addr == ddhr_pkg::OFS_OUT1 || st.aw_addr == ddhr_pkg::OFS_OUT2)
        |=> s_axi_bresp == ddhr_pkg::RESP_ERR && $stable(st.hold))
        else $error("output latch written");

    // ************************************************************
    // Read view checks
    // ************************************************************
    // Views are cut from one value per channel, so no format can keep a stale copy
    rd_right_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == ddhr_pkg::OFS_C1R12
        |=> s_axi_rdata == {20'h0_0000, $past(st.hold[0])}) else $error("ch1 right view");
    rd_left_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == ddhr_pkg::OFS_C2L12
        |=> s_axi_rdata == {16'h0000, $past(st.hold[1]), 4'h0}) else $error("ch2 left view");
    rd_byte_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == ddhr_pkg::OFS_C1R8
        |=> s_axi_rdata == {24'h00_0000, $past(st.hold[0][11:4])})
        else $error("ch1 byte view");
    rd_dual_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == ddhr_pkg::OFS_D12L
        |=> s_axi_rdata == {$past(st.hold[1]), 4'h0, $past(st.hold[0]), 4'h0})
        else $error("dual left view");
    rd_latch_a: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == ddhr_pkg::OFS_OUT1
        |=> s_axi_rdata == {20'h0_0000, $past(st.latch[0])})
        else $error("ch1 latch view");

    // ************************************************************
    // Bus answer checks
    // ************************************************************
    // An answer must stand until taken, or the master could lose a response code
    b_stand_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    r_stand_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    wr_answer_a: assert property (wr_go
        |=> s_axi_bvalid) else $error("write not answered");

    // ************************************************************
    // Per-channel transfer checks
    // ************************************************************
    // Soft load outranks a pending hardware load, so the keep check leaves it out
    for (genvar ch = 0; ch < 2; ch++) begin : g_chan_chk
        hw_stage_a: assert property (hw_edge[ch] && st.ten[ch]
            |=> st.pipe[ch][0]) else $error("hw edge not staged");
        pipe_step_a: assert property (st.pipe[ch][0]
            |=> st.pipe[ch][1]) else $error("hw stage not advanced");
        follow_hold_a: assert property (!st.ten[ch]
            |=> st.latch[ch] == $past(st.hold[ch])) else $error("untriggered transfer");
        soft_load_a: assert property (st.ten[ch] && st.swtrig[ch] && !st.sw_done[ch]
            |=> st.latch[ch] == $past(st.hold[ch])) else $error("soft transfer");
        latch_keep_a: assert property (st.ten[ch] && !st.swtrig[ch] && !st.pipe[ch][1]
            |=> $stable(st.latch[ch])) else $error("latch moved without trigger");
        soft_clear_a: assert property (st.sw_done[ch]
            && !(wr_go && st.aw_addr == ddhr_pkg::OFS_SWTRIG)
            |=> !st.swtrig[ch]) else $error("soft bit kept");
    end

    dual_wr_c: cover property (wr_go && st.aw_addr == ddhr_pkg::OFS_D12L);
    hw_load_c: cover property (st.ten[1] && st.pipe[1][1]);
    sw_load_c: cover property (st.sw_done[0] ##1 !st.swtrig[0]);
    soft_ch2_c: cover property (st.ten[1] && st.swtrig[1] && !st.sw_done[1]);
    ro_write_c: cover property (wr_go && st.aw_addr == ddhr_pkg::OFS_OUT1);

endmodule

// ==== ddhr_tb.sv ====
// Testbench: self-checking register and transfer tests of the holding-register bank
`timescale 1ns/1ps

module testbench;
    // ************************************************************
    // Signals
    // ************************************************************
    logic                        sys_clk = 1'b0;
    logic                        resetn = 1'b0;
    logic [ddhr_pkg::ADDR_W-1:0] s_axi_awaddr = 8'h00;
    logic                        s_axi_awvalid = 1'b0;
    logic                        s_axi_awready;
    logic [31:0]                 s_axi_wdata = 32'h0000_0000;
    logic [3:0]                  s_axi_wstrb = 4'hf;
    logic                        s_axi_wvalid = 1'b0;
    logic                        s_axi_wready;
    logic [1:0]                  s_axi_bresp;
    logic                        s_axi_bvalid;
    logic                        s_axi_bready = 1'b0;
    logic [ddhr_pkg::ADDR_W-1:0] s_axi_araddr = 8'h00;
    logic                        s_axi_arvalid = 1'b0;
    logic                        s_axi_arready;
    logic [31:0]                 s_axi_rdata;
    logic [1:0]                  s_axi_rresp;
    logic                        s_axi_rvalid;
    logic                        s_axi_rready = 1'b0;
    logic [1:0]                  hw_trigger = 2'h0;
    logic [11:0]                 ch1_output_latch;
    logic [11:0]                 ch2_output_latch;
    logic [11:0]                 pre1;
    logic [11:0]                 pre2;
    logic [11:0]                 exp1 = 12'h000;
    logic [11:0]                 exp2 = 12'h000;
    logic [31:0]                 rd;
    logic [1:0]                  rsp;
    int                          mismatches = 0;
    int                          tests_run = 0;

    always #2 sys_clk = ~sys_clk;

    ddhr_regs u_ddhr_regs (.sys_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hw_trigger, .ch1_output_latch,
        .ch2_output_latch);

    // ************************************************************
    // Bus tasks and comparison
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    // Ready is sampled at the falling edge, so each valid drops right after its own taking edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic pa;
        logic pw;
        logic ta;
        logic tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(negedge sys_clk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge sys_clk);
            if (ta) begin
                s_axi_awvalid <= 1'b0;
                pa = 1'b0;
            end
            if (tw) begin
                s_axi_wvalid <= 1'b0;
                pw = 1'b0;
            end
        end
        do @(negedge sys_clk); while (s_axi_bvalid !== 1'b1);
        pre1 = ch1_output_latch;
        pre2 = ch2_output_latch;
        rsp = s_axi_bresp;
        @(posedge sys_clk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge sys_clk); while (s_axi_arready !== 1'b1);
        @(posedge sys_clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge sys_clk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge sys_clk);
        s_axi_rready <= 1'b0;
    endtask

    // Latch must still be old when the response shows, and new one edge later
    task automatic write_expect(input logic [7:0] a, input logic [31:0] d,
                                input logic [11:0] n1, input logic [11:0] n2);
        axi_write(a, d);
        check(32'(rsp), 32'(ddhr_pkg::RESP_OKAY), "write resp");
        check(32'(pre1), 32'(exp1), "ch1 latch early");
        check(32'(pre2), 32'(exp2), "ch2 latch early");
        @(negedge sys_clk);
        check(32'(ch1_output_latch), 32'(n1), "ch1 latch");
        check(32'(ch2_output_latch), 32'(n2), "ch2 latch");
        exp1 = n1;
        exp2 = n2;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            axi_read(8'h08 + 8'(4 * i));
            check(rd, ddhr_pkg::WORD_ZERO, "reset value");
        end
        check(32'({ch2_output_latch, ch1_output_latch}), 32'h0000_0000, "latch reset");
        $display("test reset done");
    endtask

    task automatic t_formats();
        write_expect(ddhr_pkg::OFS_C1R12, 32'hffff_fabc, 12'habc, exp2);
        axi_read(ddhr_pkg::OFS_C1L12);
        check(rd, 32'h0000_abc0, "left view");
        write_expect(ddhr_pkg::OFS_C1L12, 32'hffff_123f, 12'h123, exp2);
        axi_read(ddhr_pkg::OFS_C1R12);
        check(rd, 32'h0000_0123, "right view");
        write_expect(ddhr_pkg::OFS_C1R8, 32'hffff_ff5a, 12'h5a0, exp2);
        axi_read(ddhr_pkg::OFS_C1R8);
        check(rd, 32'h0000_005a, "byte view");
        write_expect(ddhr_pkg::OFS_C2R12, 32'hffff_f456, exp1, 12'h456);
        write_expect(ddhr_pkg::OFS_C2L12, 32'hffff_789f, exp1, 12'h789);
        write_expect(ddhr_pkg::OFS_C2R8, 32'hffff_ffc3, exp1, 12'hc30);
        axi_read(ddhr_pkg::OFS_C2L12);
        check(rd, 32'h0000_c300, "ch2 left view");
        $display("test formats done");
    endtask

    task automatic t_dual();
        write_expect(ddhr_pkg::OFS_D12R, 32'hf456_f789, 12'h789, 12'h456);
        write_expect(ddhr_pkg::OFS_D12L, 32'habc1_def2, 12'hdef, 12'habc);
        axi_read(ddhr_pkg::OFS_D12R);
        check(rd, 32'h0abc_0def, "dual view");
        // Byte strobe merges into the current view, upper holding bits survive
        @(posedge sys_clk);
        s_axi_wstrb <= 4'h1;
        write_expect(ddhr_pkg::OFS_C1R12, 32'h0000_0012, 12'hd12, exp2);
        @(posedge sys_clk);
        s_axi_wstrb <= 4'hf;
        $display("test dual done");
    endtask

    task automatic t_readonly();
        axi_write(ddhr_pkg::OFS_OUT1, 32'h0000_0111);
        check(32'(rsp), 32'(ddhr_pkg::RESP_ERR), "latch write resp");
        @(negedge sys_clk);
        check(32'(ch1_output_latch), 32'(exp1), "latch kept");
        axi_read(ddhr_pkg::OFS_OUT2);
        check(rd, 32'(exp2), "latch read");
        axi_read(8'h28);
        check(32'(rsp), 32'(ddhr_pkg::RESP_ERR), "unmapped read resp");
        $display("test readonly done");
    endtask

    // Two sync flops plus the three-cycle transfer, counted at falling edges from the drive
    task automatic hw_fire(input logic [1:0] m, input logic [11:0] v, input string msg);
        int k;
        k = 0;
        @(posedge sys_clk);
        hw_trigger <= m;
        while ((m[1] ? ch2_output_latch : ch1_output_latch) !== v && k < 20) begin
            @(negedge sys_clk);
            k++;
        end
        check(32'(k), 32'h0000_0006, msg);
        @(posedge sys_clk);
        hw_trigger <= 2'h0;
    endtask

    task automatic t_trigger();
        axi_write(ddhr_pkg::OFS_CTRL, 32'h0004_0004);
        axi_write(ddhr_pkg::OFS_C1R12, 32'h0000_00aa);
        axi_write(ddhr_pkg::OFS_C2R12, 32'h0000_0321);
        repeat (4) @(negedge sys_clk);
        check(32'({ch2_output_latch, ch1_output_latch}), 32'({exp2, exp1}), "held");
        axi_write(ddhr_pkg::OFS_SWTRIG, 32'h0000_0001);
        check(32'(pre1), 32'(exp1), "soft early");
        @(negedge sys_clk);
        check(32'(ch1_output_latch), 32'h0000_00aa, "soft load");
        exp1 = 12'h0aa;
        axi_read(ddhr_pkg::OFS_SWTRIG);
        check(32'(rd[1:0]), 32'h0000_0000, "soft bit cleared");
        hw_fire(2'h2, 12'h321, "ch2 hardware delay");
        axi_write(ddhr_pkg::OFS_C2R12, 32'h0000_0266);
        axi_write(ddhr_pkg::OFS_C1R12, 32'h0000_0155);
        axi_write(ddhr_pkg::OFS_SWTRIG, 32'h0000_0002);
        check(32'(pre2), 32'h0000_0321, "ch2 soft early");
        @(negedge sys_clk);
        check(32'(ch2_output_latch), 32'h0000_0266, "ch2 soft load");
        check(32'(ch1_output_latch), 32'h0000_00aa, "ch1 untouched");
        axi_read(ddhr_pkg::OFS_SWTRIG);
        check(32'(rd[1:0]), 32'h0000_0000, "ch2 soft bit cleared");
        hw_fire(2'h1, 12'h155, "ch1 hardware delay");
        $display("test trigger done");
    endtask

    // ************************************************************
    // Sequence, verdict and watchdog
    // ************************************************************
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        t_reset();
        t_formats();
        t_dual();
        t_readonly();
        t_trigger();
        test_done();
    end

    // Whole run needs well under two thousand cycles
    initial begin
        #40000;
        mismatches++;
        $display("CHECK FAILED t=%0t watchdog expired", $time);
        test_done();
    end
endmodule
